// ===== logic/sxp_pkg.sv
// Shared types and constants of the shift chain expansion port
`default_nettype none
package sxp_pkg;

  // Chain geometry
  localparam int unsigned CHAIN_BITS = 256;
  localparam int unsigned LEN_W = 9;
  localparam int unsigned IDX_W = 8;
  localparam logic [LEN_W-1:0] LEN_MAX = 9'h100;
  localparam logic [LEN_W-1:0] LEN_ZERO = 9'h000;
  localparam logic [IDX_W-1:0] IDX_ZERO = 8'h00;

  // Timing: link clock period, slowest allowed shift clock
  localparam int unsigned SYS_PERIOD_NS = 100;
  localparam int unsigned LINK_PERIOD_NS = 160;
  localparam int unsigned SCLK_MIN_HZ = 150000;
  localparam int unsigned SCLK_HALF_MAX_NS = 1000000000 / (2 * SCLK_MIN_HZ);
  localparam int unsigned HALF_MAX_CYC = SCLK_HALF_MAX_NS / LINK_PERIOD_NS;
  localparam int unsigned XFER_MAX_NS = 215000;
  localparam int unsigned XFER_MAX_SYS_CYC = XFER_MAX_NS / SYS_PERIOD_NS;
  // Half shift clock period in link cycles; 4 leaves room for the
  // two-flop input synchroniser ahead of each sample point
  localparam int unsigned HALF_CYC = 4;
  localparam int unsigned TMR_W = 5;
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(HALF_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 5'h00;

  // Pin levels after reset
  localparam logic LOAD_RESET = 1'h0;
  localparam logic SCLK_IDLE = 1'h0;

  typedef enum logic {
    rising_clock_rising_load,
    rising_clock_low_load
  } sxp_chain_e;

  typedef enum logic {
    write_shift_chain,
    read_shift_chain
  } sxp_op_e;

  // One request from the user side
  typedef struct packed {
    sxp_op_e op;
    logic [CHAIN_BITS-1:0] wdata;
  } sxp_cmd_s;

  // One transfer as handed to the link side
  typedef struct packed {
    sxp_op_e op;
    sxp_chain_e chain;
    logic [LEN_W-1:0] len;
    logic [CHAIN_BITS-1:0] wdata;
  } sxp_job_s;

endpackage
`default_nettype wire

// ===== logic/sxp_cmd_buffer.sv
// Two-entry command buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sxp_cmd_buffer (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire sxp_pkg::sxp_cmd_s in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output sxp_pkg::sxp_cmd_s out_data
);

  typedef struct packed {
    sxp_pkg::sxp_cmd_s [1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic in_ready;
    logic out_valid;
  } sxp_buf_s;

  sxp_buf_s cur;
  sxp_buf_s next_cur;
  logic push;
  logic pop;

  always_comb begin
    next_cur = cur;
    push = in_valid && cur.in_ready;
    pop = cur.out_valid && out_ready;
    if (push) begin
      next_cur.mem[cur.wr_ptr] = in_data;
      next_cur.wr_ptr = !cur.wr_ptr;
    end
    if (pop) begin
      next_cur.rd_ptr = !cur.rd_ptr;
    end
    if (push && !pop) begin
      next_cur.count = cur.count + 2'h1;
    end else if (pop && !push) begin
      next_cur.count = cur.count - 2'h1;
    end
    // Flags are registered so that ready depends on no input
    next_cur.in_ready = (next_cur.count != 2'h2);
    next_cur.out_valid = (next_cur.count != 2'h0);
    if (sys_rst) begin
      next_cur = '0;
      next_cur.in_ready = 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
  end

  assign in_ready = cur.in_ready;
  assign out_valid = cur.out_valid;
  assign out_data = cur.mem[cur.rd_ptr];

endmodule
`default_nettype wire

// ===== logic/sxp_expansion_port.sv
// Shift chain expansion port: command side and link side sequencer
// Behaviour
// - Input and output chains each up to 256 bits, lengths independent.
// - Types rising_clock_rising_load and rising_clock_low_load are built.
// - Each direction's chosen type sets the load strobe polarity of its own transfers.
// - Separate type and length settings per direction; matching pair used.
// - Settings may change between transfers; next transfer takes them.
// - One request runs the whole clock, load and data sequence.
// - Only write_shift_chain and read_shift_chain move data.
// - Shift clock runs at 150 kHz or faster.
// - A 32 bit chain read or write finishes within 215 us.
// - Runs stand-alone; no outside sequencing of bits needed.
`timescale 1ns/1ps
`default_nettype none
module sxp_expansion_port (
  // System clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link clock
  input wire logic link_clk,
  // Command stream
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sxp_pkg::sxp_cmd_s cmd,
  // Chain settings
  input wire sxp_pkg::sxp_chain_e input_chain_type,
  input wire sxp_pkg::sxp_chain_e output_chain_type,
  input wire logic [sxp_pkg::LEN_W-1:0] input_chain_length,
  input wire logic [sxp_pkg::LEN_W-1:0] output_chain_length,
  // Read results
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [sxp_pkg::CHAIN_BITS-1:0] rd_data,
  // Status
  output logic busy,
  output logic wr_done,
  // Shift chain pins
  output logic sclk,
  output logic load,
  output logic sdo,
  input wire logic sdi
);

  typedef enum logic [1:0] {
    sys_idle,
    sys_wait
  } sxp_sys_e;

  typedef enum logic [2:0] {
    lnk_idle,
    lnk_preload,
    lnk_preload_rel,
    lnk_low,
    lnk_high,
    lnk_latch,
    lnk_latch_rel
  } sxp_lnk_e;

  // System clock domain state
  typedef struct packed {
    sxp_sys_e st;
    logic req_tgl;
    logic [2:0] ack_sync;
    sxp_pkg::sxp_job_s job;
    logic rd_valid;
    logic [sxp_pkg::CHAIN_BITS-1:0] rd_data;
    logic busy;
    logic wr_done;
  } sxp_sys_s;

  // Link clock domain state
  typedef struct packed {
    logic [1:0] rst_sync;
    sxp_lnk_e st;
    logic [2:0] req_sync;
    logic [1:0] sdi_sync;
    sxp_pkg::sxp_job_s job;
    logic [sxp_pkg::IDX_W-1:0] idx;
    logic [sxp_pkg::TMR_W-1:0] tmr;
    logic ack_tgl;
    logic [sxp_pkg::CHAIN_BITS-1:0] result;
    logic sclk;
    logic load;
    logic sdo;
  } sxp_lnk_s;

  sxp_sys_s s_cur;
  sxp_sys_s next_s;
  sxp_lnk_s l_cur;
  sxp_lnk_s next_l;

  logic buf_valid;
  logic buf_pop;
  sxp_pkg::sxp_cmd_s buf_cmd;

  // Zero or oversize lengths run as a full chain
  function automatic logic [sxp_pkg::LEN_W-1:0] fit_len(
    input logic [sxp_pkg::LEN_W-1:0] len
  );
    if (len == sxp_pkg::LEN_ZERO || len > sxp_pkg::LEN_MAX) begin
      return sxp_pkg::LEN_MAX;
    end
    return len;
  endfunction

  // Level of the load pin while the strobe is not asserted
  function automatic logic load_rest(input sxp_pkg::sxp_chain_e chain);
    return (chain == sxp_pkg::rising_clock_low_load);
  endfunction

  sxp_cmd_buffer u_cmd_buffer (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_cmd)
  );

  // ---------------- System domain ----------------

  always_comb begin
    next_s = s_cur;
    buf_pop = 1'h0;
    next_s.ack_sync = {s_cur.ack_sync[1:0], l_cur.ack_tgl};
    next_s.wr_done = 1'h0;
    if (s_cur.rd_valid && rd_ready) begin
      next_s.rd_valid = 1'h0;
    end
    unique case (s_cur.st)
      sys_idle: begin
        // A read waits until the previous result was taken, so the
        // buffer backs up and no result is overwritten
        if (buf_valid && (buf_cmd.op == sxp_pkg::write_shift_chain ||
            !s_cur.rd_valid)) begin
          buf_pop = 1'h1;
          next_s.job.op = buf_cmd.op;
          next_s.job.wdata = buf_cmd.wdata;
          if (buf_cmd.op == sxp_pkg::read_shift_chain) begin
            next_s.job.chain = input_chain_type;
            next_s.job.len = fit_len(input_chain_length);
          end else begin
            next_s.job.chain = output_chain_type;
            next_s.job.len = fit_len(output_chain_length);
          end
          next_s.req_tgl = !s_cur.req_tgl;
          next_s.busy = 1'h1;
          next_s.st = sys_wait;
        end
      end
      sys_wait: begin
        // Job held stable while the link side works on it
        if (s_cur.ack_sync[2] != s_cur.ack_sync[1]) begin
          next_s.busy = 1'h0;
          next_s.st = sys_idle;
          if (s_cur.job.op == sxp_pkg::read_shift_chain) begin
            next_s.rd_data = l_cur.result;
            next_s.rd_valid = 1'h1;
          end else begin
            next_s.wr_done = 1'h1;
          end
        end
      end
      default: begin
        next_s.st = sys_idle;
      end
    endcase
    if (sys_rst) begin
      next_s = '0;
      next_s.st = sys_idle;
      next_s.ack_sync = s_cur.ack_sync;
      buf_pop = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    s_cur <= next_s;
  end

  // ---------------- Link domain ----------------

  always_comb begin
    next_l = l_cur;
    next_l.rst_sync = {l_cur.rst_sync[0], sys_rst};
    next_l.req_sync = {l_cur.req_sync[1:0], s_cur.req_tgl};
    next_l.sdi_sync = {l_cur.sdi_sync[0], sdi};
    // half period timer, HALF_CYC not above HALF_MAX_CYC
    if (l_cur.tmr != sxp_pkg::TMR_ZERO) begin
      next_l.tmr = l_cur.tmr - 1'h1;
    end
    unique case (l_cur.st)
      lnk_idle: begin
        next_l.sclk = sxp_pkg::SCLK_IDLE;
        if (l_cur.req_sync[2] != l_cur.req_sync[1]) begin
          // whole job latched, sequence runs alone
          next_l.job = s_cur.job;
          next_l.idx = sxp_pkg::IDX_W'(s_cur.job.len - 1'h1);
          next_l.tmr = sxp_pkg::TMR_LAST;
          next_l.load = load_rest(s_cur.job.chain);
          if (s_cur.job.op == sxp_pkg::read_shift_chain) begin
            next_l.result = '0;
            next_l.st = lnk_preload;
          end else begin
            next_l.sdo = s_cur.job.wdata[
              sxp_pkg::IDX_W'(s_cur.job.len - 1'h1)];
            next_l.st = lnk_low;
          end
        end
      end
      lnk_preload: begin
        // parallel inputs captured before first clock
        next_l.load = !load_rest(l_cur.job.chain);
        if (l_cur.tmr == sxp_pkg::TMR_ZERO) begin
          next_l.tmr = sxp_pkg::TMR_LAST;
          next_l.st = lnk_preload_rel;
        end
      end
      lnk_preload_rel: begin
        next_l.load = load_rest(l_cur.job.chain);
        if (l_cur.tmr == sxp_pkg::TMR_ZERO) begin
          next_l.tmr = sxp_pkg::TMR_LAST;
          next_l.st = lnk_low;
        end
      end
      lnk_low: begin
        next_l.sclk = 1'h0;
        if (l_cur.tmr == sxp_pkg::TMR_ZERO) begin
          // sample just before the rising edge
          if (l_cur.job.op == sxp_pkg::read_shift_chain) begin
            next_l.result[l_cur.idx] = l_cur.sdi_sync[1];
          end
          next_l.sclk = 1'h1;
          next_l.tmr = sxp_pkg::TMR_LAST;
          next_l.st = lnk_high;
        end
      end
      lnk_high: begin
        if (l_cur.tmr == sxp_pkg::TMR_ZERO) begin
          next_l.sclk = 1'h0;
          next_l.tmr = sxp_pkg::TMR_LAST;
          // up to 256 bits, one count per direction
          if (l_cur.idx == sxp_pkg::IDX_ZERO) begin
            if (l_cur.job.op == sxp_pkg::read_shift_chain) begin
              next_l.ack_tgl = !l_cur.ack_tgl;
              next_l.st = lnk_idle;
            end else begin
              next_l.st = lnk_latch;
            end
          end else begin
            next_l.idx = l_cur.idx - 1'h1;
            next_l.sdo = l_cur.job.wdata[l_cur.idx - 1'h1];
            next_l.st = lnk_low;
          end
        end
      end
      lnk_latch: begin
        // outputs latched only after the last bit
        // rising edge or low level strobe per type
        next_l.load = !load_rest(l_cur.job.chain);
        if (l_cur.tmr == sxp_pkg::TMR_ZERO) begin
          next_l.tmr = sxp_pkg::TMR_LAST;
          next_l.st = lnk_latch_rel;
        end
      end
      lnk_latch_rel: begin
        next_l.load = load_rest(l_cur.job.chain);
        if (l_cur.tmr == sxp_pkg::TMR_ZERO) begin
          // 32 bits take about 43 us here
          next_l.ack_tgl = !l_cur.ack_tgl;
          next_l.st = lnk_idle;
        end
      end
      default: begin
        next_l.st = lnk_idle;
      end
    endcase
    // Reset arrives through a two-flop synchroniser
    if (l_cur.rst_sync[1]) begin
      next_l = '0;
      next_l.rst_sync = {l_cur.rst_sync[0], sys_rst};
      next_l.st = lnk_idle;
      next_l.sclk = sxp_pkg::SCLK_IDLE;
      next_l.load = sxp_pkg::LOAD_RESET;
    end
  end

  always_ff @(posedge link_clk) begin
    l_cur <= next_l;
  end

  // data leaves only through the two operations
  assign rd_valid = s_cur.rd_valid;
  assign rd_data = s_cur.rd_data;
  assign busy = s_cur.busy;
  assign wr_done = s_cur.wr_done;
  // pins driven by the link sequencer alone
  assign sclk = l_cur.sclk;
  assign load = l_cur.load;
  assign sdo = l_cur.sdo;

endmodule
`default_nettype wire

// ===== verification/sxp_expansion_port_monitor.sv
// Checker for the expansion port streams and chain pins
`timescale 1ns/1ps
`default_nettype none
module sxp_expansion_port_monitor (
  // Clocks and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clk,
  // Streams and status
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [sxp_pkg::CHAIN_BITS-1:0] rd_data,
  input wire logic busy,
  input wire logic wr_done,
  // Chain pins
  input wire logic sclk,
  input wire logic load,
  input wire logic sdo
);
  // One high half of the shift clock, then low
  sequence high_half;
    sclk [*4] ##1 !sclk;
  endsequence

  // One low half of the shift clock between two bits
  sequence low_half;
    !sclk [*4];
  endsequence

  sequence result_held;
    rd_valid && $stable(rd_data);
  endsequence

  clock_high_a: assert property (
    @(posedge link_clk) disable iff (sys_rst) $rose(sclk) |-> high_half)
    else $error("shift clock high half wrong");
  clock_low_a: assert property (
    @(posedge link_clk) disable iff (sys_rst) $fell(sclk) |-> low_half)
    else $error("shift clock low half too short");
  data_steady_a: assert property (
    @(posedge link_clk) disable iff (sys_rst) sclk |-> $stable(sdo))
    else $error("serial data moved with clock high");
  load_steady_a: assert property (
    @(posedge link_clk) disable iff (sys_rst) sclk |-> $stable(load))
    else $error("load moved with clock high");
  clock_in_job_a: assert property (
    @(posedge link_clk) disable iff (sys_rst) $rose(sclk) |-> busy)
    else $error("shift clock outside a transfer");
  done_pulse_a: assert property (
    @(posedge clock) disable iff (sys_rst) wr_done |=> !wr_done)
    else $error("write done longer than one cycle");
  done_after_busy_a: assert property (
    @(posedge clock) disable iff (sys_rst) wr_done |-> $past(busy))
    else $error("write done without a transfer");
  result_hold_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    rd_valid && !rd_ready |=> result_held)
    else $error("read result dropped or changed");
  result_busy_a: assert property (
    @(posedge clock) disable iff (sys_rst) $rose(rd_valid) |-> $past(busy))
    else $error("read result without a transfer");
endmodule

bind sxp_expansion_port sxp_expansion_port_monitor
  sxp_expansion_port_monitor_i (
  .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .busy(busy), .wr_done(wr_done),
  .sclk(sclk), .load(load), .sdo(sdo)
);
`default_nettype wire

// ===== verification/sxp_chain_model.sv
// Output latch chain and parallel-load input chain on the port pins
`timescale 1ns/1ps
`default_nettype none
module sxp_chain_model (
  // Chain pins
  input wire logic sclk,
  input wire logic load,
  input wire logic sdo,
  output logic sdi,
  // Chain setup and parallel sides
  input wire sxp_pkg::sxp_chain_e in_type,
  input wire sxp_pkg::sxp_chain_e out_type,
  input wire logic [sxp_pkg::LEN_W-1:0] in_len,
  input wire logic [sxp_pkg::CHAIN_BITS-1:0] par_in,
  output logic [sxp_pkg::CHAIN_BITS-1:0] par_out
);
  logic [sxp_pkg::CHAIN_BITS-1:0] osr = '0;
  logic [sxp_pkg::CHAIN_BITS-1:0] isr = '0;
  logic [sxp_pkg::CHAIN_BITS-1:0] q_rise = '0;
  logic [sxp_pkg::CHAIN_BITS-1:0] q_low = '0;
  logic low_in;
  assign low_in = (in_type == sxp_pkg::rising_clock_low_load);
  always @(load or par_in)
    if (load ^ low_in)
      isr <= par_in;
  always @(posedge sclk) begin
    osr <= {osr[sxp_pkg::CHAIN_BITS-2:0], sdo};
    if (!(load ^ low_in))
      isr <= {isr[sxp_pkg::CHAIN_BITS-2:0], 1'h0};
  end
  always @(posedge load)
    q_rise <= osr;
  always @(load or osr)
    if (!load)
      q_low = osr;
  assign par_out = (out_type == sxp_pkg::rising_clock_low_load) ?
    q_low : q_rise;
  // Last stage of a chain of in_len bits drives the line
  assign sdi = isr[sxp_pkg::IDX_W'(in_len - 9'h001)];
endmodule
`default_nettype wire

// ===== verification/sxp_expansion_port_tb_top.sv
// Self-checking bench for the shift chain expansion port
`timescale 1ns/1ps
`default_nettype none
module sxp_expansion_port_tb_top;
  typedef logic [sxp_pkg::CHAIN_BITS-1:0] sxp_word_t;
  logic clock = 1'h0;
  logic link_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic cmd_valid = 1'h0;
  logic rd_ready = 1'h0;
  logic cmd_ready, rd_valid, busy, wr_done, sclk, load, sdo, sdi;
  sxp_pkg::sxp_cmd_s cmd = '0;
  sxp_pkg::sxp_chain_e in_type = sxp_pkg::rising_clock_rising_load;
  sxp_pkg::sxp_chain_e out_type = sxp_pkg::rising_clock_rising_load;
  logic [sxp_pkg::LEN_W-1:0] in_len = 9'h020;
  logic [sxp_pkg::LEN_W-1:0] out_len = 9'h020;
  logic [sxp_pkg::LEN_W-1:0] lens [3] = '{9'h001, 9'h020, 9'h100};
  sxp_word_t rd_data, par_out, wd;
  sxp_word_t par_in = {8{32'hC3A5_0F97}};
  int miscompares = 0;
  int n_checks = 0;
  int cyc;

  always #50 clock = ~clock;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  sxp_expansion_port sxp_expansion_port_i (
    .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .input_chain_type(in_type), .output_chain_type(out_type),
    .input_chain_length(in_len), .output_chain_length(out_len),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .busy(busy), .wr_done(wr_done),
    .sclk(sclk), .load(load), .sdo(sdo), .sdi(sdi)
  );
  sxp_chain_model sxp_chain_model_i (
    .sclk(sclk), .load(load), .sdo(sdo), .sdi(sdi),
    .in_type(in_type), .out_type(out_type), .in_len(in_len),
    .par_in(par_in), .par_out(par_out)
  );

  task automatic chk(input string nm, input sxp_word_t e, input sxp_word_t g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic sxp_word_t mask(input logic [8:0] n);
    return (n >= 9'h100) ? '1 : ((256'h1 << n) - 256'h1);
  endfunction

  task automatic issue(input sxp_pkg::sxp_op_e op, input sxp_word_t d);
    @(negedge clock);
    cmd = {op, d};
    cmd_valid = 1'h1;
    for (cyc = 0; cyc < 9000 && cmd_ready !== 1'h1; cyc++)
      @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'h0;
  endtask

  task automatic wait_wr;
    for (cyc = 0; cyc < 5000 && wr_done !== 1'h1; cyc++)
      @(negedge clock);
    chk("wr_done", 256'h1, 256'(wr_done));
  endtask

  // Result is held until the bench takes it
  task automatic take(input sxp_word_t e);
    for (cyc = 0; cyc < 5000 && rd_valid !== 1'h1; cyc++)
      @(negedge clock);
    chk("rd_data", e, rd_data);
    rd_ready = 1'h1;
    @(negedge clock);
    rd_ready = 1'h0;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #6000000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'h0;
    repeat (8) @(negedge clock);
    chk("idle pins", 256'h0, 256'({sclk, load, sdo, busy}));
    // Both types and lengths 1, 32 and 256, each direction set on its own
    foreach (lens[i]) for (int t = 0; t < 2; t++) begin
      out_type = sxp_pkg::sxp_chain_e'(t);
      in_type = sxp_pkg::sxp_chain_e'(1 - t);
      out_len = lens[i];
      in_len = lens[2 - i];
      wd = t ? ~{8{32'h5A3C_96E1}} : {8{32'h5A3C_96E1}};
      issue(sxp_pkg::write_shift_chain, wd);
      wait_wr();
      chk("chain out", wd & mask(out_len), par_out & mask(out_len));
      if (out_len == 9'h020) chk("wr time", 1, 256'(cyc <= 2150));
      issue(sxp_pkg::read_shift_chain, '0);
      take(par_in & mask(in_len));
      if (in_len == 9'h020) chk("rd time", 1, 256'(cyc <= 2150));
    end
    // Back to back with different settings per direction
    out_type = sxp_pkg::rising_clock_low_load;
    in_type = sxp_pkg::rising_clock_rising_load;
    out_len = 9'h011;
    in_len = 9'h0C8;
    wd = {8{32'h0F1E_2D3B}};
    issue(sxp_pkg::write_shift_chain, wd);
    issue(sxp_pkg::read_shift_chain, '0);
    wait_wr();
    chk("chain out", wd & mask(9'h011), par_out & mask(9'h011));
    take(par_in & mask(9'h0C8));
    // Reader stalls; buffer fills until it refuses, then drains
    in_len = 9'h008;
    repeat (3) issue(sxp_pkg::read_shift_chain, '0);
    @(negedge clock);
    chk("cmd_ready", 256'h0, 256'(cmd_ready));
    repeat (3) take(par_in & mask(9'h008));
    final_report();
  end
endmodule
`default_nettype wire
